// *** rtl/ctrl_src_defs.vh ***
/*
 * Constants for the control source selector: register indices, reset values,
 * selector encodings.
 * Assumes plain register port with read data one cycle after the read strobe.
 */
`ifndef CTRL_SRC_DEFS_VH
`define CTRL_SRC_DEFS_VH

`define ADDR_W              4
`define SEL_W               16
`define DATA_W              16

// Register indices
`define REG_QUICK_STOP      4'h0
`define REG_FWD_START       4'h1
`define REG_REV_START       4'h2
`define REG_START_LATCH     4'h3
`define REG_REV_ENABLE      4'h4
`define REG_FAULT_RESET     4'h5
`define REG_EXT_FAULT       4'h6
`define REG_TERM_MODE       4'h7
`define REG_SPEED_ONE       4'h8
`define REG_SPEED_TWO       4'h9
`define REG_STATUS          4'hA

// Reset values
`define RST_QUICK_STOP      16'h0000
`define RST_FWD_START       16'h0001
`define RST_REV_START       16'h0000
`define RST_START_LATCH     16'h0000
`define RST_REV_ENABLE      16'h0002
`define RST_FAULT_RESET     16'h0001
`define RST_EXT_FAULT       16'h0000
`define RST_TERM_MODE       16'h0010
`define RST_SPEED_ONE       16'h0000
`define RST_SPEED_TWO       16'h0002

// Control selector encoding
`define CSEL_OFF            16'h0000
`define CSEL_DI_FIRST       16'h0001
`define CSEL_DI_LAST        16'h0008
`define CSEL_AO_FIRST       16'h0009
`define CSEL_AO_LAST        16'h000A
`define CSEL_DO_FIRST       16'h000B
`define CSEL_DO_LAST        16'h000F
`define CSEL_ON             16'h0010
`define CSEL_UR_FIRST       16'h0011
`define CSEL_UR_LAST        16'h0019

// Speed selector encoding
`define SSEL_AI_ONE         16'h0000
`define SSEL_AI_TWO         16'h0001
`define SSEL_FF_ZERO        16'h0002
`define SSEL_KEYPAD         16'h0003
`define SSEL_PID            16'h0004
`define SSEL_MASTER         16'h0005
`define SSEL_FIELDBUS       16'h0006
`define SSEL_PROGRAM        16'h0007
`define SSEL_FREQ_IN        16'h0008
`define SSEL_FF_FIRST       16'h0009
`define SSEL_FF_LAST        16'h0010
`define SSEL_NONE           4'hF

// Status bit positions
`define ST_LATCH_FWD        0
`define ST_LATCH_REV        1

`endif

// *** rtl/speed_ref_mux.v ***
/*
 * Speed reference source decoder: maps a speed selector value to a source
 * index 0..16, or index 0 with src_valid low for values out of range.
 * Assumes the selector comes from a register.
 */
`include "ctrl_src_defs.vh"

module speed_ref_mux
(
    // Selector
    input  wire [`SEL_W-1:0] sel,
    // Decoded source index
    output reg  [4:0]        src_index,
    output reg               src_valid
);

    always @*
    begin
        if (sel <= `SSEL_FF_LAST)
        begin
            src_index = sel[4:0];
            src_valid = 1'b1;
        end
        else
        begin
            src_index = 5'h00;
            src_valid = 1'b0;
        end
    end

endmodule // speed_ref_mux

// *** rtl/control_source_selector.v ***
/*
 * Control source selector: selector registers pick the source of each drive
 * control input and of two speed references; optional start latching.
 * Assumes synchronous terminal inputs and a plain register port master.
 */
// Added by the designer: the address-and-strobe port and the address map.
`include "ctrl_src_defs.vh"

// Function
// - Quick-stop selector: 0 off, 1-8 DI, 9-10 AO, 11-15 DO, 16 on, 17-25 user.
// - Forward start uses own selector, same encoding, default 1.
// - Reverse start uses own selector, same encoding, default 0.
// - One latch setting for both starts: 0 off, 1 on, default off.
// - Reverse enable uses own selector, same encoding, default 2.
// - Fault reset uses own selector, same encoding, default 1.
// - External fault uses own selector, same encoding, default 0.
// - Terminal mode uses own selector, same encoding, default 16.
// - Two speed selectors: AI, FF0, keypad..freq input, FF1-8; defaults 0, 2.
module control_source_selector #(
    parameter SPEED_W = 16
)
(
    // Clock and reset
    input  wire                    core_clk,
    input  wire                    reset_n,
    // Register port
    input  wire [`ADDR_W-1:0]      reg_addr,
    input  wire [`DATA_W-1:0]      reg_wdata,
    input  wire                    reg_write,
    input  wire                    reg_read,
    output reg  [`DATA_W-1:0]      reg_rdata,
    // Control sources
    input  wire [7:0]              digital_input,
    input  wire [1:0]              analog_output,
    input  wire [4:0]              digital_output,
    input  wire [8:0]              user_register,
    // Speed sources
    input  wire [SPEED_W-1:0]      analog_input_one,
    input  wire [SPEED_W-1:0]      analog_input_two,
    input  wire [9*SPEED_W-1:0]    fixed_frequency,
    input  wire [SPEED_W-1:0]      keypad_speed,
    input  wire [SPEED_W-1:0]      pid_output,
    input  wire [SPEED_W-1:0]      master_speed,
    input  wire [SPEED_W-1:0]      fieldbus_speed,
    input  wire [SPEED_W-1:0]      program_speed,
    input  wire [SPEED_W-1:0]      frequency_input,
    // Control functions
    output reg                     quick_stop,
    output reg                     forward_start,
    output reg                     reverse_start,
    output reg                     reverse_enable,
    output reg                     fault_reset,
    output reg                     external_fault,
    output reg                     terminal_mode,
    output reg  [SPEED_W-1:0]      speed_ref_one,
    output reg  [SPEED_W-1:0]      speed_ref_two
);

    reg  [`SEL_W-1:0]   quick_stop_source_select_q;
    reg  [`SEL_W-1:0]   forward_start_source_select_q;
    reg  [`SEL_W-1:0]   reverse_start_source_select_q;
    reg                 start_latch_select_q;
    reg  [`SEL_W-1:0]   reverse_enable_source_select_q;
    reg  [`SEL_W-1:0]   fault_reset_source_select_q;
    reg  [`SEL_W-1:0]   external_fault_source_select_q;
    reg  [`SEL_W-1:0]   terminal_mode_source_select_q;
    reg  [`SEL_W-1:0]   speed_ref_one_source_select_q;
    reg  [`SEL_W-1:0]   speed_ref_two_source_select_q;
    reg                 fwd_held_q;
    reg                 rev_held_q;
    wire [4:0]          spd_one_idx;
    wire                spd_one_ok;
    wire [4:0]          spd_two_idx;
    wire                spd_two_ok;
    wire                qs_d;
    wire                fwd_src;
    wire                rev_src;
    // Next values of the registered outputs
    wire                forward_start_d;
    wire                reverse_start_d;
    wire                reverse_enable_d;
    wire                fault_reset_d;
    wire                external_fault_d;
    wire                terminal_mode_d;
    wire [SPEED_W-1:0]  speed_ref_one_d;
    wire [SPEED_W-1:0]  speed_ref_two_d;

    // Latch setting keeps only its enable bit
    localparam [`SEL_W-1:0] LATCH_RST = `RST_START_LATCH;

    // Decodes a control selector; out-of-range values give inactive
    function pick_ctrl;
        input [`SEL_W-1:0] sel;
        input [7:0]        di;
        input [1:0]        ao;
        input [4:0]        dout;
        input [8:0]        ur;
        reg   [`SEL_W-1:0] off;
        begin
            pick_ctrl = 1'b0;
            if (sel >= `CSEL_DI_FIRST && sel <= `CSEL_DI_LAST)
            begin
                off = sel - `CSEL_DI_FIRST;
                pick_ctrl = di[off[2:0]];
            end
            else if (sel >= `CSEL_AO_FIRST && sel <= `CSEL_AO_LAST)
            begin
                off = sel - `CSEL_AO_FIRST;
                pick_ctrl = ao[off[0]];
            end
            else if (sel >= `CSEL_DO_FIRST && sel <= `CSEL_DO_LAST)
            begin
                off = sel - `CSEL_DO_FIRST;
                pick_ctrl = dout[off[2:0]];
            end
            else if (sel == `CSEL_ON)
                pick_ctrl = 1'b1;
            else if (sel >= `CSEL_UR_FIRST && sel <= `CSEL_UR_LAST)
            begin
                off = sel - `CSEL_UR_FIRST;
                pick_ctrl = ur[off[3:0]];
            end
        end
    endfunction

    // Selects one speed source by decoded index
    function [SPEED_W-1:0] pick_speed;
        input [4:0]           idx;
        input                 ok;
        input [SPEED_W*16-1:0] base;
        input [9*SPEED_W-1:0] ff;
        begin
            pick_speed = {SPEED_W{1'b0}};
            if (ok)
            begin
                if (idx == `SSEL_FF_ZERO)
                    pick_speed = ff[SPEED_W-1:0];
                else if (idx >= `SSEL_FF_FIRST)
                    pick_speed = ff[(idx - `SSEL_FF_FIRST + 1)*SPEED_W +: SPEED_W];
                else
                    pick_speed = base[idx*SPEED_W +: SPEED_W];
            end
        end
    endfunction

    wire [SPEED_W*16-1:0] speed_base;
    assign speed_base = {{7*SPEED_W{1'b0}}, frequency_input, program_speed,
                         fieldbus_speed, master_speed, pid_output, keypad_speed,
                         {SPEED_W{1'b0}}, analog_input_two, analog_input_one};

    speed_ref_mux u_spd_one
    (
        .sel       (speed_ref_one_source_select_q),
        .src_index (spd_one_idx),
        .src_valid (spd_one_ok)
    );

    speed_ref_mux u_spd_two
    (
        .sel       (speed_ref_two_source_select_q),
        .src_index (spd_two_idx),
        .src_valid (spd_two_ok)
    );

    assign qs_d    = pick_ctrl(quick_stop_source_select_q, digital_input,
                               analog_output, digital_output, user_register);
    assign fwd_src = pick_ctrl(forward_start_source_select_q, digital_input,
                               analog_output, digital_output, user_register);
    assign rev_src = pick_ctrl(reverse_start_source_select_q, digital_input,
                               analog_output, digital_output, user_register);

    // With latching on, quick stop releases held starts and wins over a new start
    assign forward_start_d  = start_latch_select_q ?
                              ((fwd_src || fwd_held_q) && !qs_d) : fwd_src;
    assign reverse_start_d  = start_latch_select_q ?
                              ((rev_src || rev_held_q) && !qs_d) : rev_src;
    assign reverse_enable_d = pick_ctrl(reverse_enable_source_select_q, digital_input,
                                        analog_output, digital_output, user_register);
    assign fault_reset_d    = pick_ctrl(fault_reset_source_select_q, digital_input,
                                        analog_output, digital_output, user_register);
    assign external_fault_d = pick_ctrl(external_fault_source_select_q, digital_input,
                                        analog_output, digital_output, user_register);
    assign terminal_mode_d  = pick_ctrl(terminal_mode_source_select_q, digital_input,
                                        analog_output, digital_output, user_register);
    assign speed_ref_one_d  = pick_speed(spd_one_idx, spd_one_ok, speed_base,
                                         fixed_frequency);
    assign speed_ref_two_d  = pick_speed(spd_two_idx, spd_two_ok, speed_base,
                                         fixed_frequency);

    // Register writes
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            quick_stop_source_select_q     <= `RST_QUICK_STOP;
            forward_start_source_select_q  <= `RST_FWD_START;
            reverse_start_source_select_q  <= `RST_REV_START;
            start_latch_select_q           <= LATCH_RST[0];
            reverse_enable_source_select_q <= `RST_REV_ENABLE;
            fault_reset_source_select_q    <= `RST_FAULT_RESET;
            external_fault_source_select_q <= `RST_EXT_FAULT;
            terminal_mode_source_select_q  <= `RST_TERM_MODE;
            speed_ref_one_source_select_q  <= `RST_SPEED_ONE;
            speed_ref_two_source_select_q  <= `RST_SPEED_TWO;
        end
        else if (reg_write)
        begin
            case (reg_addr)
                `REG_QUICK_STOP:  quick_stop_source_select_q     <= reg_wdata;
                `REG_FWD_START:   forward_start_source_select_q  <= reg_wdata;
                `REG_REV_START:   reverse_start_source_select_q  <= reg_wdata;
                `REG_START_LATCH: start_latch_select_q           <= reg_wdata[0];
                `REG_REV_ENABLE:  reverse_enable_source_select_q <= reg_wdata;
                `REG_FAULT_RESET: fault_reset_source_select_q    <= reg_wdata;
                `REG_EXT_FAULT:   external_fault_source_select_q <= reg_wdata;
                `REG_TERM_MODE:   terminal_mode_source_select_q  <= reg_wdata;
                `REG_SPEED_ONE:   speed_ref_one_source_select_q  <= reg_wdata;
                `REG_SPEED_TWO:   speed_ref_two_source_select_q  <= reg_wdata;
                default:          ;
            endcase
        end
    end

    // Read data, valid the cycle after the strobe only
    always @(posedge core_clk)
    begin
        if (!reset_n)
            reg_rdata <= {`DATA_W{1'b0}};
        else if (reg_read)
        begin
            case (reg_addr)
                `REG_QUICK_STOP:  reg_rdata <= quick_stop_source_select_q;
                `REG_FWD_START:   reg_rdata <= forward_start_source_select_q;
                `REG_REV_START:   reg_rdata <= reverse_start_source_select_q;
                `REG_START_LATCH: reg_rdata <= {{(`DATA_W-1){1'b0}}, start_latch_select_q};
                `REG_REV_ENABLE:  reg_rdata <= reverse_enable_source_select_q;
                `REG_FAULT_RESET: reg_rdata <= fault_reset_source_select_q;
                `REG_EXT_FAULT:   reg_rdata <= external_fault_source_select_q;
                `REG_TERM_MODE:   reg_rdata <= terminal_mode_source_select_q;
                `REG_SPEED_ONE:   reg_rdata <= speed_ref_one_source_select_q;
                `REG_SPEED_TWO:   reg_rdata <= speed_ref_two_source_select_q;
                `REG_STATUS:      reg_rdata <= {{(`DATA_W-2){1'b0}}, rev_held_q, fwd_held_q};
                default:          reg_rdata <= {`DATA_W{1'b0}};
            endcase
        end
        else
            reg_rdata <= {`DATA_W{1'b0}};
    end

    // Start latches; quick stop clears, and wins over a new start
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            fwd_held_q <= 1'b0;
            rev_held_q <= 1'b0;
        end
        else if (!start_latch_select_q || qs_d)
        begin
            fwd_held_q <= 1'b0;
            rev_held_q <= 1'b0;
        end
        else
        begin
            if (fwd_src)
                fwd_held_q <= 1'b1;
            if (rev_src)
                rev_held_q <= 1'b1;
        end
    end

    // Registered outputs, sampled every clock
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            quick_stop     <= 1'b0;
            forward_start  <= 1'b0;
            reverse_start  <= 1'b0;
            reverse_enable <= 1'b0;
            fault_reset    <= 1'b0;
            external_fault <= 1'b0;
            terminal_mode  <= 1'b0;
            speed_ref_one  <= {SPEED_W{1'b0}};
            speed_ref_two  <= {SPEED_W{1'b0}};
        end
        else
        begin
            quick_stop     <= qs_d;
            forward_start  <= forward_start_d;
            reverse_start  <= reverse_start_d;
            reverse_enable <= reverse_enable_d;
            fault_reset    <= fault_reset_d;
            external_fault <= external_fault_d;
            terminal_mode  <= terminal_mode_d;
            speed_ref_one  <= speed_ref_one_d;
            speed_ref_two  <= speed_ref_two_d;
        end
    end

endmodule // control_source_selector

// *** testbench/control_source_checker.sv ***
/*
 Checker for the control source selector: quick stop, start and read port.
 Assumes it is bound to the top module and sees only its ports.
*/
`include "ctrl_src_defs.vh"

module control_source_checker
(
    // Clock and reset
    input logic        core_clk,
    input logic        reset_n,
    // Register port
    input logic [3:0]  reg_addr,
    input logic [15:0] reg_wdata,
    input logic        reg_write,
    input logic        reg_read,
    input logic [15:0] reg_rdata,
    // Sources and functions
    input logic [7:0]  digital_input,
    input logic [1:0]  analog_output,
    input logic [4:0]  digital_output,
    input logic [8:0]  user_register,
    input logic        quick_stop,
    input logic        forward_start,
    input logic        reverse_start
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] qs_q, fw_q, rv_q;
    logic        lt_q, qs_e, fw_e, rv_e, fw_set, stop_l;
    logic [23:0] src;

    function automatic logic ctl(input logic [15:0] s, input logic [23:0] v);
        ctl = 1'b0;
        if (s >= 16'h0001 && s <= 16'h000F) ctl = v[s - 16'h0001];
        if (s == 16'h0010) ctl = 1'b1;
        if (s >= 16'h0011 && s <= 16'h0019) ctl = v[s - 16'h0002];
    endfunction

    // Shadow of the selectors seen by the design
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            {qs_q, fw_q, rv_q, lt_q} <= {16'h0000, 16'h0001, 16'h0000, 1'b0};
        else if (reg_write)
        begin
            if (reg_addr == `REG_QUICK_STOP) qs_q <= reg_wdata;
            if (reg_addr == `REG_FWD_START) fw_q <= reg_wdata;
            if (reg_addr == `REG_REV_START) rv_q <= reg_wdata;
            if (reg_addr == `REG_START_LATCH) lt_q <= reg_wdata[0];
        end
    end

    assign src = {user_register, digital_output, analog_output, digital_input};
    assign qs_e = ctl(qs_q, src);
    assign fw_e = ctl(fw_q, src);
    assign rv_e = ctl(rv_q, src);
    assign fw_set = lt_q && fw_e && !qs_e;
    assign stop_l = lt_q && qs_e;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_quick_stop_map:
        assert property ($past(reset_n) |-> quick_stop == $past(qs_e))
        else $error("quick stop differs from its source");
    a_fwd_plain:
        assert property ($past(reset_n) && !$past(lt_q) |-> forward_start == $past(fw_e))
        else $error("forward start differs from its source");
    a_rev_plain:
        assert property ($past(reset_n) && !$past(lt_q) |-> reverse_start == $past(rv_e))
        else $error("reverse start differs from its source");
    a_start_latch_set:
        assert property ($past(reset_n) && $past(fw_set) |-> forward_start)
        else $error("latched forward start missing");
    a_latch_release:
        assert property ($past(reset_n) && $past(stop_l) |-> !forward_start && !reverse_start)
        else $error("quick stop did not release the starts");
    a_latch_hold:
        assert property ($past(lt_q) && lt_q && forward_start && !qs_e |=> forward_start)
        else $error("held forward start dropped");
    a_rdata_idle:
        assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_read_fwd_sel:
        assert property ($past(reg_read) && $past(reg_addr) == `REG_FWD_START
                         |-> reg_rdata == $past(fw_q))
        else $error("forward selector read wrong");
endmodule // control_source_checker

bind control_source_selector control_source_checker chk
(
    .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .digital_input, .analog_output, .digital_output, .user_register,
    .quick_stop, .forward_start, .reverse_start
);

// *** testbench/terminal_model.sv ***
/*
 Drive terminals and speed sources feeding the selector.
 Assumes the bench sets src and base; speed code k shows base plus k.
*/
module terminal_model
(
    // Control sources
    output logic [7:0]   digital_input,
    output logic [1:0]   analog_output,
    output logic [4:0]   digital_output,
    output logic [8:0]   user_register,
    // Speed sources by selector code
    output logic [15:0]  spd [0:16],
    output logic [143:0] fixed_frequency
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [23:0] src = 24'h000000;
    logic [15:0] base = 16'h5A00;

    assign {user_register, digital_output, analog_output, digital_input} = src;

    always_comb
    begin
        for (int k = 0; k < 17; k++)
            spd[k] = base + k[15:0];
        fixed_frequency[15:0] = spd[2];
        for (int k = 1; k < 9; k++)
            fixed_frequency[16*k +: 16] = spd[8+k];
    end
endmodule // terminal_model

// *** testbench/control_source_selector_test.sv ***
/*
 Self-checking bench: register port, control and speed decoding, latching.
 Assumes the terminal model and the bound checker.
*/
`include "ctrl_src_defs.vh"

module control_source_selector_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic         core_clk = 1'b0;
    logic         reset_n = 1'b0;
    logic [3:0]   reg_addr = 4'h0;
    logic [15:0]  reg_wdata = 16'h0000;
    logic         reg_write = 1'b0;
    logic         reg_read = 1'b0;
    logic [15:0]  reg_rdata, sref_one, sref_two, rd, sv, ex;
    logic [23:0]  pat;
    logic [143:0] ff;
    logic [15:0]  spd [0:16];
    logic [7:0]   di;
    logic [1:0]   ao;
    logic [4:0]   dout;
    logic [8:0]   ur;
    logic [6:0]   func;
    int           miscompares = 0;
    int           cmp_count = 0;

    localparam logic [15:0] rst_val [0:9] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000,
        16'h0002, 16'h0001, 16'h0000, 16'h0010, 16'h0000, 16'h0002};
    localparam logic [3:0] ctl_addr [0:6] = '{`REG_QUICK_STOP, `REG_FWD_START,
        `REG_REV_START, `REG_REV_ENABLE, `REG_FAULT_RESET, `REG_EXT_FAULT, `REG_TERM_MODE};

    always #5 core_clk = ~core_clk;

    terminal_model tm
    (
        .digital_input(di), .analog_output(ao), .digital_output(dout),
        .user_register(ur), .spd(spd), .fixed_frequency(ff)
    );

    control_source_selector #(.SPEED_W(16)) uut
    (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .digital_input(di), .analog_output(ao),
        .digital_output(dout), .user_register(ur), .analog_input_one(spd[0]),
        .analog_input_two(spd[1]), .fixed_frequency(ff), .keypad_speed(spd[3]),
        .pid_output(spd[4]), .master_speed(spd[5]), .fieldbus_speed(spd[6]),
        .program_speed(spd[7]), .frequency_input(spd[8]), .quick_stop(func[0]),
        .forward_start(func[1]), .reverse_start(func[2]), .reverse_enable(func[3]),
        .fault_reset(func[4]), .external_fault(func[5]), .terminal_mode(func[6]),
        .speed_ref_one(sref_one), .speed_ref_two(sref_two)
    );

    function automatic logic ctl(input logic [15:0] s, input logic [23:0] v);
        ctl = 1'b0;
        if (s >= 16'h0001 && s <= 16'h000F) ctl = v[s - 16'h0001];
        if (s == 16'h0010) ctl = 1'b1;
        if (s >= 16'h0011 && s <= 16'h0019) ctl = v[s - 16'h0002];
    endfunction

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic set_src(input logic [23:0] v);
        @(posedge core_clk);
        tm.src <= v;
    endtask

    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic test_done;
        $display("checks %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #100000;
        miscompares++;
        test_done;
    end

    initial
    begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            rd_reg(i[3:0], rd);
            chk("reset value", rst_val[i], rd);
        end
        wr_reg(4'hB, 16'h1234);
        rd_reg(4'hB, rd);
        chk("unmapped place", 16'h0000, rd);
        wr_reg(`REG_START_LATCH, 16'hFFFE);
        rd_reg(`REG_START_LATCH, rd);
        chk("latch setting", 16'h0000, rd);
        for (int k = 0; k < 7; k++)
            for (int s = 0; s < 28; s++)
                for (int n = 0; n < 2; n++)
                begin
                    sv = (s == 27) ? 16'hFFFF : s[15:0];
                    pat = n ? 24'hA5C35A : 24'h5A3CA5;
                    set_src(pat);
                    wr_reg(ctl_addr[k], sv);
                    settle;
                    chk("control output", {15'h0000, ctl(sv, pat)}, {15'h0000, func[k]});
                end
        for (int k = 0; k < 2; k++)
            for (int s = 0; s < 19; s++)
            begin
                sv = (s == 18) ? 16'hFFFF : s[15:0];
                @(posedge core_clk);
                tm.base <= k ? 16'hC300 : 16'h5A00;
                wr_reg(`REG_SPEED_ONE + k[3:0], sv);
                settle;
                ex = (s < 17) ? (k ? 16'hC300 : 16'h5A00) + sv : 16'h0000;
                chk("speed reference", ex, k ? sref_two : sref_one);
            end
        wr_reg(`REG_QUICK_STOP, 16'h0003);
        wr_reg(`REG_FWD_START, 16'h0001);
        wr_reg(`REG_REV_START, 16'h0004);
        set_src(24'h000000);
        wr_reg(`REG_START_LATCH, 16'hFFFF);
        rd_reg(`REG_START_LATCH, rd);
        chk("latch setting", 16'h0001, rd);
        for (int b = 0; b < 2; b++)
        begin
            set_src(b ? 24'h000008 : 24'h000001);
            set_src(24'h000000);
            settle;
            settle;
            chk("held start", 16'h0001, {15'h0000, func[1+b]});
            rd_reg(`REG_STATUS, rd);
            chk("latch status", b ? 16'h0002 : 16'h0001, rd);
            set_src(24'h000004);
            settle;
            chk("released start", 16'h0000, {15'h0000, func[1+b]});
            rd_reg(`REG_STATUS, rd);
            chk("latch status", 16'h0000, rd);
            set_src(24'h000000);
            settle;
            chk("released start", 16'h0000, {15'h0000, func[1+b]});
        end
        set_src(24'h000001);
        set_src(24'h000000);
        wr_reg(`REG_START_LATCH, 16'h0000);
        settle;
        chk("unlatched start", 16'h0000, {15'h0000, func[1]});
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_reg(`REG_QUICK_STOP, rd);
        chk("reset value", 16'h0000, rd);
        settle;
        chk("terminal mode", 16'h0001, {15'h0000, func[6]});
        test_done;
    end
endmodule // control_source_selector_test
